// File: hw/interrupt_vector_mapper.sv
`timescale 1ns/1ps
module interrupt_vector_mapper
    import irq_map_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        timer0_low_request,
    input  wire logic        timer0_high_request,
    input  wire logic        timer1_high_request,
    input  wire logic        timer1_low_request,
    input  wire logic        pulse1_low_request,
    input  wire logic        pulse1_high_request,
    input  wire logic        pulse0_high_request,
    input  wire logic        pulse0_low_request,
    output logic             irq,
    output logic [4:0]       grant_slot,
    output logic [1:0]       grant_level,
    output logic [15:0]      grant_vector
);
    // all registered state of the block in one word
    typedef struct packed {
        logic [7:0]       sync1;
        logic [7:0]       sync2;
        logic [7:0]       prev;
        logic [SLOTS-1:0] status;
        logic [SLOTS-1:0] mask;
        logic [LEVEL_REGS*LEVEL_REG_W-1:0] levels;
        logic             wr_pend;
        logic [11:0]      idx;
        logic [31:0]      rdata;
        logic             irq;
        logic [4:0]       gslot;
        logic [1:0]       glevel;
        logic [15:0]      gvec;
        logic             ready;
        logic             resp;
    } state_type;

    // reset image: levels all ones, no winner, bus answer ready
    localparam state_type RESET_STATE = '{
        sync1   : '0,
        sync2   : '0,
        prev    : '0,
        status  : '0,
        mask    : '0,
        levels  : {LEVEL_REGS{LEVEL_RESET}},
        wr_pend : 1'b0,
        idx     : '0,
        rdata   : '0,
        irq     : 1'b0,
        gslot   : '0,
        glevel  : IDLE_LEVEL,
        gvec    : IDLE_VECTOR,
        ready   : 1'b1,
        resp    : RESP_OKAY
    };

    // state, next state and helpers
    state_type        s_q, s_d;
    logic [SLOTS-1:0] events;
    logic [SLOTS-1:0] pend;
    logic             arb_any;
    logic [4:0]       arb_slot;
    logic [1:0]       arb_level;
    logic [11:0]      a_idx;
    logic             a_valid;
    // register decode of the pending write and of the address phase
    logic             wr_level;
    logic             wr_status;
    logic             wr_mask;
    logic [2:0]       wr_reg;
    logic             rd_level;
    logic [2:0]       rd_reg;
    logic [31:0]      rd_word;

    // word index of the address phase and its qualifier
    assign a_idx   = haddr[IDX_MSB:IDX_LSB];
    assign a_valid = hsel && hready && htrans[1];
    assign pend    = s_q.status & s_q.mask;

    // index falls inside the level register block
    function automatic logic level_hit(input logic [11:0] idx);
        logic [11:0] rel;
        rel       = idx - LEVEL_BASE_IDX;
        level_hit = (idx >= LEVEL_BASE_IDX) && (rel < 12'(LEVEL_REGS));
    endfunction : level_hit

    // level register number of an index that hits
    function automatic logic [2:0] level_sel(input logic [11:0] idx);
        logic [11:0] rel;
        rel       = idx - LEVEL_BASE_IDX;
        level_sel = rel[2:0];
    endfunction : level_sel

    // grant word: vector on top, then irq flag, level and slot
    function automatic logic [31:0] grant_word(input logic [15:0] vec,
                                               input logic        flag,
                                               input logic [1:0]  lvl,
                                               input logic [4:0]  slt);
        grant_word = {vec, 8'h00, flag, lvl, slt};
    endfunction : grant_word

    // rising edges of synchronised requests placed into their slots
    always_comb begin
        logic [7:0] rise;
        rise   = s_q.sync2 & ~s_q.prev;
        events = '0;
        // timer channels
        events[SLOT_T0_LOW]  = rise[0];
        events[SLOT_T0_HIGH] = rise[1];
        events[SLOT_T1_HIGH] = rise[2];
        events[SLOT_T1_LOW]  = rise[3];
        // pulse generator channels
        events[SLOT_P1_LOW]  = rise[4];
        events[SLOT_P1_HIGH] = rise[5];
        events[SLOT_P0_HIGH] = rise[6];
        events[SLOT_P0_LOW]  = rise[7];
    end

    // winner among pending unmasked slots
    irq_arbiter u_arb (
        .pending (pend),
        .levels  (s_q.levels),
        .any     (arb_any),
        .slot    (arb_slot),
        .level   (arb_level)
    );

    // decode shared by the write and the read side
    always_comb begin
        wr_level  = s_q.wr_pend && level_hit(s_q.idx);
        wr_status = s_q.wr_pend && (s_q.idx == STATUS_IDX);
        wr_mask   = s_q.wr_pend && (s_q.idx == MASK_IDX);
        wr_reg    = level_sel(s_q.idx);
        rd_level  = level_hit(a_idx);
        rd_reg    = level_sel(a_idx);
    end

    // read mux of the address phase index
    always_comb begin
        rd_word = '0;
        if (rd_level) begin
            rd_word[LEVEL_REG_W-1:0] =
                s_q.levels[rd_reg*LEVEL_REG_W +: LEVEL_REG_W];
        end else if (a_idx == STATUS_IDX) begin
            rd_word[SLOTS-1:0] = s_q.status;
        end else if (a_idx == MASK_IDX) begin
            rd_word[SLOTS-1:0] = s_q.mask;
        end else if (a_idx == GRANT_IDX) begin
            rd_word = grant_word(s_q.gvec, s_q.irq, s_q.glevel, s_q.gslot);
        end
        // unassigned reads give zero
    end

    // bus writes, sticky status and the request synchronisers
    always_comb begin
        logic [SLOTS-1:0] clr;
        clr       = '0;
        s_d       = s_q;
        // two flops on every request pin before the edge detector
        s_d.sync1 = {pulse0_low_request, pulse0_high_request, pulse1_high_request,
                     pulse1_low_request, timer1_low_request, timer1_high_request,
                     timer0_high_request, timer0_low_request};
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;
        // data phase of a write lands at its closing edge
        if (wr_level) begin
            s_d.levels[wr_reg*LEVEL_REG_W +: LEVEL_REG_W] =
                hwdata[LEVEL_REG_W-1:0];
        end
        if (wr_status) begin
            clr = hwdata[SLOTS-1:0];
        end
        if (wr_mask) begin
            s_d.mask = hwdata[SLOTS-1:0];
        end
        // writes to any other index fall away
        // write one to clear; a new event in the same cycle wins
        s_d.status  = (s_q.status & ~clr) | events;
        // remember the address phase for the data phase
        s_d.wr_pend = a_valid && hwrite;
        if (a_valid) begin
            s_d.idx = a_idx;
        end
        // read data registered at the address edge, shown in the data phase
        s_d.rdata   = (a_valid && !hwrite) ? rd_word : '0;
        // interrupt line and winner registered for the core
        s_d.irq     = |pend;
        s_d.gslot   = arb_any ? arb_slot : '0;
        s_d.glevel  = arb_any ? arb_level : IDLE_LEVEL;
        s_d.gvec    = arb_any ? slot_vector(arb_slot) : IDLE_VECTOR;
        // bus answer is zero wait and always okay
        s_d.ready   = 1'b1;
        s_d.resp    = RESP_OKAY;
    end

    // registered state; clock enable low freezes all of it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= RESET_STATE;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // every output straight from the state register
    assign hrdata       = s_q.rdata;
    assign hreadyout    = s_q.ready;
    assign hresp        = s_q.resp;
    assign irq          = s_q.irq;
    assign grant_slot   = s_q.gslot;
    assign grant_level  = s_q.glevel;
    assign grant_vector = s_q.gvec;
endmodule : interrupt_vector_mapper

// File: hw/irq_arbiter.sv
`timescale 1ns/1ps
module irq_arbiter
    import irq_map_pkg::*;
(
    input  wire logic [SLOTS-1:0]   pending,
    input  wire logic [2*SLOTS-1:0] levels,
    output logic                    any,
    output logic [4:0]              slot,
    output logic [1:0]              level
);
    // level 0 is highest; scan downward so lowest slot wins ties
    always_comb begin
        any   = 1'b0;
        slot  = 5'h00;
        level = IDLE_LEVEL;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (pending[i] && (!any || levels[2*i +: 2] <= level)) begin
                any   = 1'b1;
                slot  = 5'(i);
                level = levels[2*i +: 2];
            end
        end
    end
endmodule : irq_arbiter

// File: hw/irq_map_pkg.sv
// Functional notes
// - timer0 low to slot 5 at fff0, timer0 high to slot 6 at ffee
// - timer1 high to slot 14 at ffde, timer1 low to slot 22 at ffce
// - pulse1 low to slot 9 at ffe8, pulse1 high to slot 10 at ffe6
// - pulse0 high to slot 12 at ffe2, pulse0 low to slot 13 at ffe0
// - reads of unassigned addresses return undefined value, here zero
// - six level registers from 0079h, reset all ones, two-bit fields
package irq_map_pkg;
    localparam int          SLOTS        = 24;
    localparam int          LEVEL_REGS   = 6;
    localparam int          SLOT_W       = 5;
    localparam logic [7:0]  LEVEL_RESET  = 8'hff;
    localparam int          LEVEL_REG_W  = 8;
    // word index field of the byte address
    localparam int          IDX_LSB      = 2;
    localparam int          IDX_MSB      = 13;
    // grant outputs with no pending request, and the bus response
    localparam logic [1:0]  IDLE_LEVEL   = 2'h3;
    localparam logic [15:0] IDLE_VECTOR  = 16'h0000;
    localparam logic        RESP_OKAY    = 1'b0;
    // register indices, byte address is four times the index
    localparam logic [11:0] LEVEL_BASE_IDX = 12'h079;
    localparam logic [11:0] STATUS_IDX     = 12'h100;
    localparam logic [11:0] MASK_IDX       = 12'h101;
    localparam logic [11:0] GRANT_IDX      = 12'h102;
    // slot numbers of mapped peripheral requests
    localparam logic [4:0] SLOT_T0_LOW  = 5'h05;
    localparam logic [4:0] SLOT_T0_HIGH = 5'h06;
    localparam logic [4:0] SLOT_P1_LOW  = 5'h09;
    localparam logic [4:0] SLOT_P1_HIGH = 5'h0a;
    localparam logic [4:0] SLOT_P0_HIGH = 5'h0c;
    localparam logic [4:0] SLOT_P0_LOW  = 5'h0d;
    localparam logic [4:0] SLOT_T1_HIGH = 5'h0e;
    localparam logic [4:0] SLOT_T1_LOW  = 5'h16;
    localparam logic [15:0] VECTOR_TOP  = 16'hfffa;

    // upper vector byte address of a slot: two bytes per slot downward
    function automatic logic [15:0] slot_vector(input logic [4:0] slot);
        slot_vector = VECTOR_TOP - {10'h000, slot, 1'b0};
    endfunction : slot_vector
endpackage : irq_map_pkg

// File: sim/interrupt_vector_mapper_tb.sv
`timescale 1ns/1ps
module interrupt_vector_mapper_tb;
    import irq_map_pkg::*;
    logic clk = 0, rst_n = 0, clk_en = 1, hsel = 0, hwrite = 0, hready, irq, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0]  htrans = 0, grant_level;
    logic [4:0]  grant_slot;
    logic [15:0] grant_vector;
    logic [7:0]  fire = 0, req;
    int n_mismatch = 0, tests_run = 0;
    logic [4:0]  slot_tab [8] = '{5, 6, 14, 22, 9, 10, 12, 13};
    logic [15:0] vec_tab [8] = '{16'hfff0, 16'hffee, 16'hffde, 16'hffce,
                                 16'hffe8, 16'hffe6, 16'hffe2, 16'hffe0};
    assign hready = hreadyout;
    always #5 clk = ~clk;
    req_source src (.clk(clk), .fire(fire), .req(req));
    interrupt_vector_mapper dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .timer0_low_request(req[0]), .timer0_high_request(req[1]),
        .timer1_high_request(req[2]), .timer1_low_request(req[3]),
        .pulse1_low_request(req[4]), .pulse1_high_request(req[5]),
        .pulse0_high_request(req[6]), .pulse0_low_request(req[7]), .irq(irq),
        .grant_slot(grant_slot), .grant_level(grant_level), .grant_vector(grant_vector));
    // one single word transfer, only to mapped places when writing
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic chk(input logic [31:0] g, e);
        tests_run++;
        if (g !== e) begin
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
            n_mismatch++;
        end
    endtask : chk
    task automatic pulse(input logic [7:0] f);
        fire <= f;
        repeat (6) @(posedge clk);
        fire <= 8'h0;
    endtask : pulse
    task automatic t_reset();
        logic [31:0] q;
        for (int k = 0; k < 6; k++) begin
            bus(0, 32'h1e4 + 4 * k, 0, q);
            chk({24'h0, q[7:0]}, 32'hff);
        end
        bus(0, 32'h0, 0, q);
        chk(q, 32'h0);
        $display("reset values done");
    endtask : t_reset
    task automatic t_irq();
        logic [31:0] q;
        pulse(8'h01);
        chk({31'h0, irq}, 32'h0);
        bus(0, 32'h400, 0, q);
        chk(q, 32'h20);
        bus(1, 32'h404, 32'h20, q);
        bus(0, 32'h404, 0, q);
        chk(q, 32'h20);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        clk_en <= 0;
        repeat (3) @(posedge clk);
        clk_en <= 1;
        bus(1, 32'h400, 32'h20, q);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        $display("interrupt mask done");
    endtask : t_irq
    task automatic t_map();
        logic [31:0] q;
        bus(1, 32'h404, 32'hffffff, q);
        for (int i = 0; i < 8; i++) begin
            pulse(8'h1 << i);
            bus(0, 32'h400, 0, q);
            chk(q, 32'h1 << slot_tab[i]);
            chk({27'h0, grant_slot}, {27'h0, slot_tab[i]});
            chk({16'h0, grant_vector}, {16'h0, vec_tab[i]});
            bus(1, 32'h400, 32'h1 << slot_tab[i], q);
        end
        $display("slot map done");
    endtask : t_map
    task automatic t_tie();
        logic [31:0] q;
        pulse(8'hc8);
        chk({27'h0, grant_slot}, 32'd12);
        bus(1, 32'h1f0, 32'hf3, q);
        bus(0, 32'h1f0, 0, q);
        chk({24'h0, q[7:0]}, 32'hf3);
        repeat (3) @(posedge clk);
        chk({25'h0, grant_level, grant_slot}, 32'd13);
        bus(0, 32'h408, 0, q);
        chk(q, 32'hffe0_008d);
        bus(1, 32'h400, 32'hffffff, q);
        $display("same level order done");
    endtask : t_tie
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // watchdog against a hang
    initial begin
        #100us;
        $display("MISMATCH %0t watchdog ran out", $time);
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        t_reset();
        t_irq();
        t_map();
        t_tie();
        test_done();
    end
endmodule : interrupt_vector_mapper_tb

// File: sim/ivm_checker.sv
`timescale 1ns/1ps
module ivm_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq,
    input wire logic [4:0]  grant_slot,
    input wire logic [1:0]  grant_level,
    input wire logic [15:0] grant_vector
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // bus answer is zero wait and okay
    ready_const_a: assert property (hreadyout) else $error("hreadyout low");
    resp_okay_a: assert property (!hresp) else $error("hresp not okay");
    // reads of an unused place give zero
    unmapped_read_a: assert property (clk_en && hsel && hready && htrans[1] && !hwrite
        && haddr == 32'h0 |=> hrdata == 32'h0) else $error("unmapped read not zero");
    // winner vector follows its slot
    grant_vector_a: assert property (grant_vector == 16'h0 ||
        grant_vector == 16'hfffa - {10'h0, grant_slot, 1'b0}) else $error("bad vector");
    idle_grant_a: assert property (grant_vector == 16'h0 |->
        grant_slot == 5'h0 && grant_level == 2'h3) else $error("bad idle grant");
    slot_range_a: assert property (grant_slot < 5'd24) else $error("slot out of range");
    // clock enable low freezes state
    grant_freeze_a: assert property (!clk_en |=> $stable(grant_slot) &&
        $stable(grant_level) && $stable(irq)) else $error("grant moved while frozen");
    read_freeze_a: assert property (!clk_en |=> $stable(hrdata)) else $error("hrdata moved");
endmodule : ivm_checker

bind interrupt_vector_mapper ivm_checker u_chk (.clk, .rst_n, .clk_en, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .irq, .grant_slot,
    .grant_level, .grant_vector);

// File: sim/req_source.sv
`timescale 1ns/1ps
module req_source (
    input wire logic       clk,
    input wire logic [7:0] fire,
    output logic     [7:0] req
);
    // peripherals raise level requests a cycle after being told
    always_ff @(posedge clk) begin
        req <= fire;
    end
endmodule : req_source
